// file: inc/rsc_pkg.sv
package rsc_pkg;

   // Strap count and the post-release pull-up hold, in platform clock cycles
   localparam int STRAP_W = 8;
   localparam int PULL_HOLD_CYC = 4;
   localparam int SYNC_STAGES = 2;

   // Straps whose pin carries a gated pull-up; ratio straps (upper bits) have none
   localparam logic [STRAP_W-1:0] PULLUP_MASK = 8'h0F;

   // Value held in the capture register until the first release
   localparam logic [STRAP_W-1:0] STRAP_RST_VAL = 8'hFF;

   // TAP reset reached by five clocks with TMS high
   localparam int TAP_TMS_ONES = 5;
   localparam logic [2:0] TAP_TMS_ONES_W3 = 3'h5;

   typedef enum logic [2:0] {
      RSC_ST_SAMPLE = 3'h1,
      RSC_ST_SETTLE = 3'h2,
      RSC_ST_RUN = 3'h4
   } rsc_state_t;

   typedef struct packed {
      logic [STRAP_W-1:0] out; // functional output level
      logic [STRAP_W-1:0] oe_n; // low while the device drives the pin
      logic [STRAP_W-1:0] pull_en; // gated pull-up enable
      logic [STRAP_W-1:0] rx_en; // input receiver enable
   } rsc_pad_ctl_t;

endpackage : rsc_pkg

// file: rtl/rsc_sync.sv
`timescale 1ns/10ps
module rsc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // First stage is read only by the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= RST_VAL;
         q <= RST_VAL;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule : rsc_sync

// file: rtl/rsc_top.sv
`timescale 1ns/10ps
module rsc_top #(
   parameter int STRAP_W = rsc_pkg::STRAP_W,
   parameter int PULL_HOLD_CYC = rsc_pkg::PULL_HOLD_CYC
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic HARD_RESET_IN_N,
   input wire logic [STRAP_W-1:0] CFG_PIN_IN,
   input wire logic [STRAP_W-1:0] FUNC_OUT,
   output rsc_pkg::rsc_pad_ctl_t CFG_PAD,
   output logic [STRAP_W-1:0] CFG_STRAP,
   output logic CFG_VALID,
   output logic CORE_RESET,
   input wire logic TAP_TRST_N,
   input wire logic TAP_TCK,
   input wire logic TAP_TMS,
   output logic TAP_RESET
);
   logic hard_reset_in_n_n_s;
   logic [STRAP_W-1:0] pin_s;
   logic trst_n_s;
   logic tck_s;
   logic tms_s;
   rsc_pkg::rsc_state_t state_r;
   rsc_pkg::rsc_state_t state_nxt;
   logic [$clog2(PULL_HOLD_CYC+1)-1:0] hold_r;
   logic [STRAP_W-1:0] strap_r;
   logic valid_r;
   logic tck_d_r;
   logic [2:0] tms_ones_r;
   logic tap_rst_r;
   logic capture;
   logic sampling;
   logic core_rst_r;
   logic tck_rise;
   logic [STRAP_W-1:0] oe_n_v;
   logic [STRAP_W-1:0] rx_en_v;
   logic [STRAP_W-1:0] pull_en_v;
   logic [STRAP_W-1:0] out_v;

   // Pins and the test port are asynchronous; two flops stand before any logic reads them
   rsc_sync #(.W(1), .RST_VAL(1'b0)) u_sync_hr (
      .clk(CLK), .rst(RST), .d(HARD_RESET_IN_N), .q(hard_reset_in_n_n_s));

   rsc_sync #(.W(STRAP_W), .RST_VAL('1)) u_sync_pin (
      .clk(CLK), .rst(RST), .d(CFG_PIN_IN), .q(pin_s));

   rsc_sync #(.W(3), .RST_VAL(3'h0)) u_sync_tap (
      .clk(CLK),
      .rst(RST),
      .d({TAP_TRST_N, TAP_TCK, TAP_TMS}),
      .q({trst_n_s, tck_s, tms_s}));

   // Sample until release, then hold pull-ups while the captured value settles
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         rsc_pkg::RSC_ST_SAMPLE: begin
            if (hard_reset_in_n_n_s) begin
               state_nxt = rsc_pkg::RSC_ST_SETTLE;
            end
         end
         rsc_pkg::RSC_ST_SETTLE: begin
            if (!hard_reset_in_n_n_s) begin
               state_nxt = rsc_pkg::RSC_ST_SAMPLE;
            end else if (hold_r == ($clog2(PULL_HOLD_CYC+1))'(PULL_HOLD_CYC - 1)) begin
               state_nxt = rsc_pkg::RSC_ST_RUN;
            end
         end
         rsc_pkg::RSC_ST_RUN: begin
            if (!hard_reset_in_n_n_s) begin
               state_nxt = rsc_pkg::RSC_ST_SAMPLE;
            end
         end
         // An illegal code falls back to sampling, where the pads are safe inputs
         default: state_nxt = rsc_pkg::RSC_ST_SAMPLE;
      endcase
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_r <= rsc_pkg::RSC_ST_SAMPLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         hold_r <= '0;
      end else if (state_r == rsc_pkg::RSC_ST_SETTLE) begin
         hold_r <= hold_r + 1'b1;
      end else begin
         hold_r <= '0;
      end
   end

   assign sampling = (state_r == rsc_pkg::RSC_ST_SAMPLE);
   // Capture at the first cycle that sees release; the pins are still inputs then
   assign capture = sampling && hard_reset_in_n_n_s;

   // Stable until the next hard reset; a glitch-free copy because only capture writes it
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         strap_r <= rsc_pkg::STRAP_RST_VAL;
      end else if (capture) begin
         strap_r <= pin_s;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         valid_r <= 1'b0;
      end else if (!hard_reset_in_n_n_s) begin
         valid_r <= 1'b0;
      end else if (capture) begin
         valid_r <= 1'b1;
      end
   end

   // A hard reset seen mid-settle drops the capture, so the straps are taken again
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         core_rst_r <= 1'b1;
      end else if (!hard_reset_in_n_n_s) begin
         core_rst_r <= 1'b1;
      end else if (capture) begin
         core_rst_r <= 1'b0;
      end
   end

   assign CFG_STRAP = strap_r;
   assign CFG_VALID = valid_r;
   assign CORE_RESET = core_rst_r;

   // Pad slices: each pin holds its own drive flop, so receiver, pull-up and driver
   // switch on one edge and the driver never fights the pull-up
   for (genvar i = 0; i < STRAP_W; i++) begin : g_pad
      logic drive_r;
      logic out_r;

      // Taken from the next state so the pad changes on the edge that enters RUN
      always_ff @(posedge CLK or posedge RST) begin
         if (RST) begin
            drive_r <= 1'b0;
         end else begin
            drive_r <= (state_nxt == rsc_pkg::RSC_ST_RUN);
         end
      end

      always_ff @(posedge CLK or posedge RST) begin
         if (RST) begin
            out_r <= 1'b0;
         end else begin
            out_r <= FUNC_OUT[i];
         end
      end

      assign oe_n_v[i] = !drive_r;
      assign rx_en_v[i] = !drive_r;
      // Ratio straps carry no pull-up; the board has to set them
      assign pull_en_v[i] = rsc_pkg::PULLUP_MASK[i] && !drive_r;
      assign out_v[i] = out_r;
   end

   assign CFG_PAD = '{out: out_v, oe_n: oe_n_v, pull_en: pull_en_v, rx_en: rx_en_v};

   // TAP reset: test reset pin, or enough TMS-high clocks; sampled edges only
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         tck_d_r <= 1'b0;
      end else begin
         tck_d_r <= tck_s;
      end
   end

   // Limitation: TCK must run far slower than CLK, as its edges are found after the synchroniser
   assign tck_rise = tck_s && !tck_d_r;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         tms_ones_r <= 3'h0;
      end else if (!trst_n_s) begin
         tms_ones_r <= 3'h0;
      end else if (tck_rise) begin
         if (!tms_s) begin
            tms_ones_r <= 3'h0;
            // Saturates so the reset holds while TMS stays high
         end else if (tms_ones_r != rsc_pkg::TAP_TMS_ONES_W3) begin
            tms_ones_r <= tms_ones_r + 3'h1;
         end
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         tap_rst_r <= 1'b1;
      end else begin
         tap_rst_r <= !trst_n_s || (tms_ones_r == rsc_pkg::TAP_TMS_ONES_W3);
      end
   end

   assign TAP_RESET = tap_rst_r;

endmodule : rsc_top

// file: sim/rsc_board.sv
`timescale 1ns/10ps
module rsc_board (
   input wire logic clk,
   input wire logic board_rst,
   input wire logic probe_hard_reset_in_n,
   input wire logic probe_trst,
   input wire logic [7:0] strap,
   input wire rsc_pkg::rsc_pad_ctl_t pad,
   output logic hard_reset_in_n_n,
   output logic trst_n,
   output logic [7:0] pin
);
   logic [7:0] tog_r = 8'h55;
   logic [7:0] res;
   always @(posedge clk) tog_r <= ~tog_r;
   // Ratio straps always carry a resistor; pulled straps need one only for a low
   assign res = ~rsc_pkg::PULLUP_MASK | ~strap;
   assign pin = (~pad.oe_n & pad.out) | (pad.oe_n & ((res & strap) | (~res & pad.pull_en)
      | (~res & ~pad.pull_en & tog_r)));
   assign hard_reset_in_n_n = ~(board_rst | probe_hard_reset_in_n);
   assign trst_n = ~(board_rst | probe_trst);
endmodule : rsc_board

// file: sim/rsc_monitor.sv
`timescale 1ns/10ps
module rsc_monitor #(
   parameter int STRAP_W = 8,
   parameter int PULL_HOLD_CYC = 4
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic HARD_RESET_IN_N,
   input wire logic [STRAP_W-1:0] CFG_PIN_IN,
   input wire logic [STRAP_W-1:0] FUNC_OUT,
   input wire rsc_pkg::rsc_pad_ctl_t CFG_PAD,
   input wire logic [STRAP_W-1:0] CFG_STRAP,
   input wire logic CFG_VALID,
   input wire logic CORE_RESET,
   input wire logic TAP_TRST_N,
   input wire logic TAP_RESET
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   property p_in; CORE_RESET |-> CFG_PAD.oe_n == '1 && CFG_PAD.rx_en == '1; endproperty
   a_in: assert property (p_in) else $error("pad not input in reset");
   property p_cap; $rose(CFG_VALID) |-> CFG_STRAP == $past(CFG_PIN_IN, 3); endproperty
   a_cap: assert property (p_cap) else $error("wrong strap capture");
   property p_rel; $rose(HARD_RESET_IN_N) && CORE_RESET |-> ##2 !CFG_VALID ##1 CFG_VALID; endproperty
   a_rel: assert property (p_rel) else $error("capture late or early");
   // Fixed hold of four cycles matches the package default
   property p_set; $rose(CFG_VALID) |-> (CFG_PAD.rx_en == '1)[*4] ##1 (CFG_PAD.rx_en == '0); endproperty
   a_set: assert property (p_set) else $error("pull-up hold wrong");
   property p_pull; CFG_PAD.pull_en == (CFG_PAD.rx_en & rsc_pkg::PULLUP_MASK); endproperty
   a_pull: assert property (p_pull) else $error("pull-up not tied to receiver");
   property p_out; !CFG_PAD.oe_n[0] |-> CFG_PAD.out == $past(FUNC_OUT) && CFG_PAD.rx_en == '0; endproperty
   a_out: assert property (p_out) else $error("output mode wrong");
   property p_hold; CFG_VALID && $past(CFG_VALID) |-> $stable(CFG_STRAP); endproperty
   a_hold: assert property (p_hold) else $error("strap changed");
   property p_fell; $fell(HARD_RESET_IN_N) |-> ##3 CORE_RESET; endproperty
   a_fell: assert property (p_fell) else $error("hard reset not seen");
   property p_trst; $fell(TAP_TRST_N) |-> ##3 TAP_RESET; endproperty
   a_trst: assert property (p_trst) else $error("test reset not seen");
endmodule : rsc_monitor
bind rsc_top rsc_monitor #(.STRAP_W(STRAP_W), .PULL_HOLD_CYC(PULL_HOLD_CYC)) u_mon (.CLK(CLK), .RST(RST),
   .HARD_RESET_IN_N(HARD_RESET_IN_N), .CFG_PIN_IN(CFG_PIN_IN), .FUNC_OUT(FUNC_OUT), .CFG_PAD(CFG_PAD),
   .CFG_STRAP(CFG_STRAP), .CFG_VALID(CFG_VALID), .CORE_RESET(CORE_RESET), .TAP_TRST_N(TAP_TRST_N),
   .TAP_RESET(TAP_RESET));

// file: sim/test_reset_strap_capture.sv
`timescale 1ns/10ps
module test_reset_strap_capture;
   logic CLK = 0, RST = 1, tck_r = 0, tms_r = 1, board_rst = 1, probe_hard_reset_in_n = 0, probe_trst = 0;
   logic [7:0] strap = 8'hFF, func_out = 8'h00, pin, cfg_strap;
   logic hard_reset_in_n_n, trst_n, valid, core_rst, tap_rst;
   rsc_pkg::rsc_pad_ctl_t pad;
   int fail_count = 0, total_checks = 0, seed = 13, exp_strap, n;
   always #2 CLK = ~CLK;
   rsc_top u_dut (.CLK(CLK), .RST(RST), .HARD_RESET_IN_N(hard_reset_in_n_n), .CFG_PIN_IN(pin), .FUNC_OUT(func_out),
      .CFG_PAD(pad), .CFG_STRAP(cfg_strap), .CFG_VALID(valid), .CORE_RESET(core_rst), .TAP_TRST_N(trst_n),
      .TAP_TCK(tck_r), .TAP_TMS(tms_r), .TAP_RESET(tap_rst));
   rsc_board u_board (.clk(CLK), .board_rst(board_rst), .probe_hard_reset_in_n(probe_hard_reset_in_n), .probe_trst(probe_trst),
      .strap(strap), .pad(pad), .hard_reset_in_n_n(hard_reset_in_n_n), .trst_n(trst_n), .pin(pin));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int k);
      repeat (k) @(negedge CLK);
   endtask : cyc
   task automatic tck(input logic tms);
      tms_r = tms;
      cyc(8);
      tck_r = 1;
      cyc(8);
      tck_r = 0;
   endtask : tck
   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : wrap_up
   initial begin
      cyc(16);
      RST = 0;
      for (int i = 0; i < 6; i++) begin
         board_rst = !i[0];
         probe_hard_reset_in_n = i[0];
         strap = (i == 0) ? 8'hFF : 8'($random(seed));
         cyc(16);
         chk(pad.oe_n, 8'hFF);
         chk(pad.rx_en, 8'hFF);
         chk({7'h0, core_rst}, 8'h01);
         chk({7'h0, tap_rst}, {7'h0, board_rst});
         chk(pad.pull_en, rsc_pkg::PULLUP_MASK);
         exp_strap = strap;
         board_rst = 0;
         probe_hard_reset_in_n = 0;
         n = 0;
         while (valid !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
         end
         chk({7'h0, valid}, 8'h01);
         chk(8'(n), 8'(rsc_pkg::SYNC_STAGES + 1));
         chk({7'h0, core_rst}, 8'h00);
         chk(cfg_strap, exp_strap[7:0]);
         strap = ~strap;
         func_out = 8'($random(seed));
         cyc(8);
         chk(cfg_strap, exp_strap[7:0]);
         chk(pin, func_out);
         chk(pad.pull_en | pad.rx_en, 8'h00);
         chk(pad.oe_n, 8'h00);
         $display("Strap test %0d done", i);
      end
      tck(0);
      chk({7'h0, tap_rst}, 8'h00);
      repeat (4) tck(1);
      chk({7'h0, tap_rst}, 8'h00);
      tck(1);
      chk({7'h0, tap_rst}, 8'h01);
      tck(0);
      chk({7'h0, tap_rst}, 8'h00);
      probe_trst = 1;
      cyc(4);
      chk({7'h0, tap_rst}, 8'h01);
      chk({7'h0, core_rst}, 8'h00);
      $display("Test reset test done");
      wrap_up();
   end
   initial begin
      #20000;
      fail_count++;
      $display("ERROR %0t: timeout", $time);
      wrap_up();
   end
endmodule : test_reset_strap_capture
